// ---- hsc_pkg.sv ----
// What this block does
// - Halt enters timers-only (11), oscillator-only (10), full stop (01), else CPU-only halt.
// - Standby select sits in mode register bits 3:2; reset loads 00.
// - Accepted request or reset ends halt; NMI or enabled maskable resumes via interrupt.
// - Maskable release with interrupts disabled continues after halt; request flag stays set.
// - Reset ending halt keeps RAM but reloads the mode register; RAM suspect if halt ran from RAM.
// - CPU-only halt keeps system clock to all logic but the CPU, whose clock gate is off.
// - CPU-only and timers-only halts sample requests at clock output falling edge.
// - Oscillator-only runs oscillator and watchdog; system clock stops, clock pin held 1.
// - Oscillator-only detects requests without system clock; restart syncs to system clock.
// - Oscillator-only releases only on NMI, external interrupt zero, or reset.
// - Timers-only clocks only 8-bit timers, 16-bit timer, watchdog; CPU-only release timing.
// - Release table: all in CPU-only, all but converter-done in timers-only, NMI/INT0 deeper.
// - Full stop halts everything including oscillator; pins float unless pin hold set.
// - Mode bit 0 pin hold keeps pins driven in full stop; reset clears it.
// - Interrupt in full stop restarts oscillator; system clock only after warm-up count.
// - Mode bit 4 picks warm-up of 2^14 (0) or 2^16 (1) cycles; reset clears.
// - Reset during full stop restarts oscillator at once with no warm-up.
package hsc_pkg;
   localparam logic [15:0] HSC_MODE_ADDR      = 16'hffd2;
   localparam int          HSC_PIN_HOLD_BIT   = 0;
   localparam int          HSC_EXX_BIT        = 1;
   localparam int          HSC_SEL_LO_BIT     = 2;
   localparam int          HSC_SEL_HI_BIT     = 3;
   localparam int          HSC_WARM_BIT       = 4;
   localparam int          HSC_WDT_EN_BIT     = 7;
   localparam logic [7:0]  HSC_MODE_RESET     = 8'h80;
   localparam logic [7:0]  HSC_MODE_WMASK     = 8'hfd;
   localparam logic [7:0]  HSC_RDATA_IDLE     = 8'h00;

   localparam logic [1:0]  HSC_SEL_CPU        = 2'h0;
   localparam logic [1:0]  HSC_SEL_STOP       = 2'h1;
   localparam logic [1:0]  HSC_SEL_OSC        = 2'h2;
   localparam logic [1:0]  HSC_SEL_TIMERS     = 2'h3;

   localparam int          HSC_NUM_SRC        = 12;
   localparam int          HSC_SRC_NMI        = 0;
   localparam int          HSC_SRC_WDT        = 1;
   localparam int          HSC_SRC_EXT_ZERO   = 2;
   localparam int          HSC_SRC_CONV_DONE  = 5;
   localparam int          HSC_SRC_EXT_ONE    = 9;
   localparam int          HSC_SRC_EXT_TWO    = 11;
   localparam logic [11:0] HSC_REL_CPU        = 12'hfff;
   localparam logic [11:0] HSC_REL_TIMERS     = 12'hfdf;
   localparam logic [11:0] HSC_REL_DEEP       = 12'h005;
   localparam logic [11:0] HSC_NMI_MASK       = 12'h001;

   localparam int          HSC_WARM_SHORT_EXP = 14;
   localparam int          HSC_WARM_LONG_EXP  = 16;
   localparam int          HSC_WARM_CNT_W     = 17;

   typedef struct packed {
      logic cpu;
      logic periph;
      logic timers;
      logic wdt;
      logic osc;
   } hsc_gate_t;

   localparam hsc_gate_t   HSC_GATE_RESET     = '{cpu: 1'b1, periph: 1'b1, timers: 1'b1, wdt: 1'b1, osc: 1'b1};

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } hsc_io_req_t;
endpackage

// ---- hsc_warmup.sv ----
`timescale 1ns/1ps
module hsc_warmup import hsc_pkg::*; #(
   parameter int CNT_W     = HSC_WARM_CNT_W,
   parameter int SHORT_CYC = 2 ** HSC_WARM_SHORT_EXP,
   parameter int LONG_CYC  = 2 ** HSC_WARM_LONG_EXP
) (
   input  wire logic clk,
   input  wire logic rst_b,
   input  wire logic ce,
   input  wire logic start,
   input  wire logic long_sel,
   output logic      busy,
   output logic      done
);
   logic [CNT_W-1:0] cnt_reg;
   logic             busy_reg;
   logic             done_reg;
   wire  [CNT_W-1:0] load_val = long_sel ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
   wire              at_end   = (cnt_reg == '0);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg  <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (ce) begin
         done_reg <= busy_reg & at_end;
         if (start) begin
            cnt_reg  <= load_val;
            busy_reg <= 1'b1;
         end else if (busy_reg) begin
            cnt_reg  <= cnt_reg - 1'b1;
            busy_reg <= ~at_end;
         end
      end
   end

   warm_load_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && start) |=> (busy && cnt_reg == ($past(long_sel) ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1))))
      else $error("warm-up length not loaded");

   assign busy = busy_reg;
   assign done = done_reg;
endmodule

// ---- hsc_halt_standby_control.sv ----
`timescale 1ns/1ps
module hsc_halt_standby_control import hsc_pkg::*; #(
   parameter int WARM_SHORT_CYC = 2 ** HSC_WARM_SHORT_EXP,
   parameter int WARM_LONG_CYC  = 2 ** HSC_WARM_LONG_EXP
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   ce,
   input  wire hsc_io_req_t            io_req,
   output logic [7:0]                  io_rdata,
   input  wire logic                   halt_exec,
   input  wire logic                   halt_from_ram,
   input  wire logic [HSC_NUM_SRC-1:0] irq_req,
   input  wire logic                   irq_enabled_state,
   input  wire logic                   exx_toggle,
   output hsc_gate_t                   gate,
   output logic                        clk_out,
   output logic                        pin_hiz,
   output logic                        halted,
   output logic                        resume_irq,
   output logic                        resume_next,
   output logic                        ram_at_risk
);
   typedef enum logic [2:0] {
      ST_ACTIVE,
      ST_HALT_CPU,
      ST_HALT_TIMERS,
      ST_HALT_OSC,
      ST_STOP,
      ST_WARM,
      ST_SYNC
   } hsc_state_t;

   hsc_state_t  state_reg;
   hsc_state_t  state_next;
   logic [7:0]  mode_reg;
   logic [7:0]  io_rdata_reg;
   hsc_gate_t   gate_reg;
   hsc_gate_t   gate_next;
   logic        clkout_reg;
   logic        pin_hiz_reg;
   logic        halted_reg;
   logic        resume_irq_reg;
   logic        resume_next_reg;
   logic        ram_risk_reg;
   logic        warm_start;
   logic        warm_busy;
   logic        warm_done;

   function automatic logic [HSC_NUM_SRC-1:0] release_mask(input hsc_state_t st);
      case (st)
         ST_HALT_CPU:    release_mask = HSC_REL_CPU;
         ST_HALT_TIMERS: release_mask = HSC_REL_TIMERS;
         ST_HALT_OSC:    release_mask = HSC_REL_DEEP;
         ST_STOP:        release_mask = HSC_REL_DEEP;
         default:        release_mask = '0;
      endcase
   endfunction

   function automatic logic clock_running(input hsc_state_t st);
      clock_running = (st == ST_ACTIVE) || (st == ST_HALT_CPU) || (st == ST_HALT_TIMERS) || (st == ST_SYNC);
   endfunction

   // Register decode; writes only land while the CPU runs
   wire       mode_hit   = (io_req.addr == HSC_MODE_ADDR);
   wire       mode_wr    = mode_hit & io_req.wr & (state_reg == ST_ACTIVE);
   wire       mode_rd    = mode_hit & io_req.rd;
   wire [7:0] mode_wval  = (io_req.wdata & HSC_MODE_WMASK) | (mode_reg & ~HSC_MODE_WMASK);
   wire [7:0] mode_base  = mode_wr ? mode_wval : mode_reg;
   wire [7:0] exx_flip   = {7'h00, exx_toggle} << HSC_EXX_BIT;
   wire [7:0] mode_next  = mode_base ^ exx_flip;
   wire [1:0] sel        = mode_reg[HSC_SEL_HI_BIT:HSC_SEL_LO_BIT];
   wire       pin_hold   = mode_reg[HSC_PIN_HOLD_BIT];
   wire       warm_long  = mode_reg[HSC_WARM_BIT];
   wire       wdt_en     = mode_reg[HSC_WDT_EN_BIT];

   // Release qualification
   wire [HSC_NUM_SRC-1:0] rel_hits = irq_req & release_mask(state_reg);
   wire       rel_any    = |rel_hits;
   wire       maskable   = |(irq_req & ~HSC_NMI_MASK);
   wire       take_irq   = irq_req[HSC_SRC_NMI] | (irq_enabled_state & maskable);
   wire       fall_edge  = clock_running(state_reg) & clkout_reg;
   wire       resume_go  = (state_next == ST_ACTIVE) & (state_reg != ST_ACTIVE);
   wire       deep_next  = (state_next == ST_STOP) || (state_next == ST_WARM);

   always_comb begin
      state_next = state_reg;
      warm_start = 1'b0;
      case (state_reg)
         ST_ACTIVE: begin
            if (halt_exec) begin
               case (sel)
                  HSC_SEL_TIMERS: state_next = ST_HALT_TIMERS;
                  HSC_SEL_OSC:    state_next = ST_HALT_OSC;
                  HSC_SEL_STOP:   state_next = ST_STOP;
                  default:        state_next = ST_HALT_CPU;
               endcase
            end
         end
         ST_HALT_CPU, ST_HALT_TIMERS: begin
            if (fall_edge && rel_any) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_HALT_OSC: begin
            if (rel_any) begin
               state_next = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (fall_edge) begin
               state_next = ST_ACTIVE;
            end
         end
         ST_STOP: begin
            if (rel_any) begin
               state_next = ST_WARM;
               warm_start = 1'b1;
            end
         end
         ST_WARM: begin
            if (warm_done) begin
               state_next = ST_ACTIVE;
            end
         end
         default: state_next = ST_ACTIVE;
      endcase
   end

   always_comb begin
      gate_next.cpu    = (state_next == ST_ACTIVE);
      gate_next.periph = (state_next == ST_ACTIVE) || (state_next == ST_HALT_CPU);
      gate_next.timers = gate_next.periph || (state_next == ST_HALT_TIMERS);
      gate_next.wdt    = wdt_en && !deep_next;
      gate_next.osc    = (state_next != ST_STOP);
   end

   hsc_warmup #(
      .CNT_W     (HSC_WARM_CNT_W),
      .SHORT_CYC (WARM_SHORT_CYC),
      .LONG_CYC  (WARM_LONG_CYC)
   ) hsc_warmup_i (
      .clk      (clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .start    (warm_start),
      .long_sel (warm_long),
      .busy     (warm_busy),
      .done     (warm_done)
   );

   // Reset returns straight to running with oscillator on and no warm-up; the reset source
   // covers oscillator settling. This block never touches RAM or other device state.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= ST_ACTIVE;
         mode_reg  <= HSC_MODE_RESET;
         gate_reg  <= HSC_GATE_RESET;
      end else if (ce) begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         gate_reg  <= gate_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         clkout_reg      <= 1'b1;
         pin_hiz_reg     <= 1'b0;
         halted_reg      <= 1'b0;
         resume_irq_reg  <= 1'b0;
         resume_next_reg <= 1'b0;
         ram_risk_reg    <= 1'b0;
         io_rdata_reg    <= HSC_RDATA_IDLE;
      end else if (ce) begin
         clkout_reg      <= clock_running(state_reg) ? ~clkout_reg : 1'b1;
         pin_hiz_reg     <= deep_next & ~pin_hold;
         halted_reg      <= (state_next != ST_ACTIVE);
         resume_irq_reg  <= resume_go & take_irq;
         resume_next_reg <= resume_go & ~take_irq;
         ram_risk_reg    <= (state_reg == ST_ACTIVE) ? (halt_exec & halt_from_ram) : (ram_risk_reg & ~resume_go);
         io_rdata_reg    <= mode_rd ? mode_reg : HSC_RDATA_IDLE;
      end
   end

   assign io_rdata    = io_rdata_reg;
   assign gate        = gate_reg;
   assign clk_out     = clkout_reg;
   assign pin_hiz     = pin_hiz_reg;
   assign halted      = halted_reg;
   assign resume_irq  = resume_irq_reg;
   assign resume_next = resume_next_reg;
   assign ram_at_risk = ram_risk_reg;

   stop_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_ACTIVE && halt_exec && sel == HSC_SEL_STOP) |=> (state_reg == ST_STOP && pin_hiz == !pin_hold))
      else $error("full stop not entered");

   mode_sel_write_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && mode_wr && !exx_toggle) |=> (sel == $past(io_req.wdata[HSC_SEL_HI_BIT:HSC_SEL_LO_BIT])))
      else $error("standby select not written");

   resume_kind_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && resume_go && !irq_req[HSC_SRC_NMI] && !irq_enabled_state) |=> (resume_next && !resume_irq))
      else $error("disabled release took the interrupt path");

   cpu_halt_clk_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_HALT_CPU) |-> (gate.periph && gate.timers && !gate.cpu))
      else $error("clock gated in cpu-only halt");

   fall_sample_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_TIMERS && !clk_out) |=> (state_reg == ST_HALT_TIMERS))
      else $error("release away from clock falling edge");

   osc_clk_high_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_HALT_OSC && $past(state_reg) == ST_HALT_OSC) |-> (clk_out && !gate.periph && !gate.timers))
      else $error("clock output not held high");

   deep_release_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_OSC && !irq_req[HSC_SRC_NMI] && !irq_req[HSC_SRC_EXT_ZERO]) |=> (state_reg == ST_HALT_OSC))
      else $error("oscillator-only released by wrong source");

   timers_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_HALT_TIMERS) |-> (gate.timers && !gate.periph && !gate.cpu))
      else $error("timers-only gating wrong");

   conv_block_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_TIMERS && irq_req == (HSC_REL_CPU & ~HSC_REL_TIMERS)) |=> (state_reg == ST_HALT_TIMERS))
      else $error("converter-done released timers-only");

   warm_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_WARM && warm_busy) |-> (!gate.cpu && gate.osc && clk_out))
      else $error("clock released before warm-up");

   cpu_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_ACTIVE && halt_exec && sel == HSC_SEL_CPU) |=> (state_reg == ST_HALT_CPU && halted))
      else $error("cpu-only halt not entered");

   timers_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_ACTIVE && halt_exec && sel == HSC_SEL_TIMERS) |=> (state_reg == ST_HALT_TIMERS))
      else $error("timers-only halt not entered");

   osc_entry_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_ACTIVE && halt_exec && sel == HSC_SEL_OSC) |=> (state_reg == ST_HALT_OSC))
      else $error("oscillator-only halt not entered");

   halt_write_block_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg != ST_ACTIVE && !exx_toggle) |=> (mode_reg == $past(mode_reg)))
      else $error("mode register changed while halted");

   irq_resume_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && resume_go && take_irq) |=> (resume_irq && !resume_next))
      else $error("accepted request did not resume through interrupt");

   cpu_release_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_CPU && clk_out && (irq_req != '0)) |=> (!halted && gate.cpu))
      else $error("cpu-only halt not released");

   cpu_conv_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_CPU && clk_out && irq_req[HSC_SRC_CONV_DONE]) |=> (state_reg == ST_ACTIVE))
      else $error("converter-done did not release cpu-only halt");

   ram_risk_set_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_ACTIVE && halt_exec && halt_from_ram) |=> ram_at_risk)
      else $error("halt from ram not flagged");

   cpu_fall_wait_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_CPU && !clk_out) |=> (state_reg == ST_HALT_CPU))
      else $error("cpu-only release away from falling edge");

   osc_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_OSC && (irq_req[HSC_SRC_NMI] || irq_req[HSC_SRC_EXT_ZERO]))
      |=> (state_reg == ST_SYNC && halted))
      else $error("oscillator-only not woken");

   sync_release_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_SYNC && clk_out) |=> (state_reg == ST_ACTIVE && (resume_irq || resume_next)))
      else $error("restart not synchronised to clock");

   timers_release_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_HALT_TIMERS && clk_out && ((irq_req & HSC_REL_TIMERS) != '0))
      |=> (state_reg == ST_ACTIVE))
      else $error("timers-only halt not released");

   stop_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_STOP) |-> (!gate.osc && !gate.cpu && !gate.timers && !gate.wdt))
      else $error("clock running in full stop");

   stop_pins_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_STOP) |=> (pin_hiz == !$past(pin_hold)))
      else $error("pin hold ignored in full stop");

   stop_wake_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_STOP && (irq_req[HSC_SRC_NMI] || irq_req[HSC_SRC_EXT_ZERO]))
      |=> (state_reg == ST_WARM && warm_busy && gate.osc && !gate.cpu))
      else $error("full stop wake skipped warm-up");

   stop_src_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_STOP && !irq_req[HSC_SRC_NMI] && !irq_req[HSC_SRC_EXT_ZERO]) |=> (state_reg == ST_STOP))
      else $error("full stop released by wrong source");

   warm_end_a: assert property (@(posedge clk) disable iff (!rst_b)
      (ce && state_reg == ST_WARM && warm_done) |=> (state_reg == ST_ACTIVE && gate.cpu))
      else $error("clock not restored after warm-up");

   active_no_warm_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == ST_ACTIVE) |-> !warm_busy)
      else $error("warm-up running while active");
endmodule

// ---- hsc_irq_model.sv ----
`timescale 1ns/1ps
module hsc_irq_model import hsc_pkg::*; (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic [HSC_NUM_SRC-1:0] raise,
   input  wire logic                   clr,
   input  wire logic                   resume_irq,
   output logic [HSC_NUM_SRC-1:0]      irq_req
);
   // Flags drop when the CPU takes the interrupt or when clr is pulsed
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_req <= '0;
      end else if (clr || resume_irq) begin
         irq_req <= '0;
      end else begin
         irq_req <= irq_req | raise;
      end
   end
endmodule

// ---- halt_standby_control_bench.sv ----
`timescale 1ns/1ps
module halt_standby_control_bench import hsc_pkg::*;;
   logic                   clk = 1'b0;
   logic                   rst_b = 1'b0;
   logic                   ce = 1'b1;
   hsc_io_req_t            io_req = '0;
   logic [7:0]             io_rdata;
   logic                   halt_exec = 1'b0;
   logic                   halt_from_ram = 1'b0;
   logic [HSC_NUM_SRC-1:0] irq_req;
   logic [HSC_NUM_SRC-1:0] raise = '0;
   logic                   clr = 1'b0;
   logic                   irq_enabled_state = 1'b0;
   logic                   exx_toggle = 1'b0;
   hsc_gate_t              gate;
   logic                   clk_out, pin_hiz, halted, resume_irq, resume_next, ram_at_risk;
   int                     failures = 0;
   int                     cmp_count = 0;
   logic [7:0]             d;
   int                     n;
   logic                   ri;

   always #50 clk = ~clk;

   hsc_halt_standby_control #(.WARM_SHORT_CYC(16), .WARM_LONG_CYC(64)) hsc_halt_standby_control_i (
      .clk(clk), .rst_b(rst_b), .ce(ce), .io_req(io_req), .io_rdata(io_rdata), .halt_exec(halt_exec),
      .halt_from_ram(halt_from_ram), .irq_req(irq_req), .irq_enabled_state(irq_enabled_state),
      .exx_toggle(exx_toggle), .gate(gate), .clk_out(clk_out), .pin_hiz(pin_hiz), .halted(halted),
      .resume_irq(resume_irq), .resume_next(resume_next), .ram_at_risk(ram_at_risk));
   hsc_irq_model hsc_irq_model_i (.clk(clk), .rst_b(rst_b), .raise(raise), .clr(clr),
      .resume_irq(resume_irq), .irq_req(irq_req));

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      io_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      io_req.wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
      @(posedge clk);
      io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      io_req.rd <= 1'b0;
      #1 v = io_rdata;
   endtask
   task automatic pulse_src(input int idx);
      @(posedge clk);
      raise <= 12'h001 << idx;
      @(posedge clk);
      raise <= '0;
   endtask
   task automatic halt_in(input logic [7:0] mode, input logic ram);
      wr_reg(HSC_MODE_ADDR, mode);
      @(posedge clk);
      halt_exec <= 1'b1;
      halt_from_ram <= ram;
      @(posedge clk);
      halt_exec <= 1'b0;
      #1 chk(halted, 1'b1);
   endtask
   task automatic wait_resume(output int cnt, output logic was_irq);
      cnt = 0;
      while (!(resume_irq || resume_next)) begin
         @(posedge clk);
         #1 cnt++;
         if (cnt > 400) begin
            failures++;
            tally_and_finish();
         end
      end
      was_irq = resume_irq;
      chk(halted, 1'b0);
   endtask
   task automatic idle_check(input int cyc);
      repeat (cyc) @(posedge clk);
      #1 chk(halted, 1'b1);
   endtask

   task automatic sc_regs();
      rd_reg(HSC_MODE_ADDR, d);
      chk(d, HSC_MODE_RESET);
      chk(gate, HSC_GATE_RESET);
      chk(pin_hiz, 1'b0);
      wr_reg(HSC_MODE_ADDR, 8'hff);
      rd_reg(HSC_MODE_ADDR, d);
      chk(d, 8'hfd);
      @(posedge clk);
      exx_toggle <= 1'b1;
      @(posedge clk);
      exx_toggle <= 1'b0;
      rd_reg(HSC_MODE_ADDR, d);
      chk(d, 8'hff);
      rd_reg(16'hffd0, d);
      chk(d, 8'h00);
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(HSC_MODE_ADDR, 8'h00);
      ce <= 1'b1;
      rd_reg(HSC_MODE_ADDR, d);
      chk(d, 8'hff);
   endtask
   task automatic sc_cpu_only();
      irq_enabled_state <= 1'b0;
      halt_in(8'h80, 1'b1);
      chk({gate.cpu, gate.periph, gate.timers}, 3'h3);
      chk(ram_at_risk, 1'b1);
      pulse_src(HSC_SRC_CONV_DONE);
      wait_resume(n, ri);
      chk(ri, 1'b0);
      #100 chk(irq_req[HSC_SRC_CONV_DONE], 1'b1);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      irq_enabled_state <= 1'b1;
      halt_in(8'h80, 1'b0);
      pulse_src(HSC_SRC_EXT_TWO);
      wait_resume(n, ri);
      chk(ri, 1'b1);
      chk(gate.cpu, 1'b1);
   endtask
   task automatic sc_timers();
      halt_in(8'h8c, 1'b0);
      chk({gate.cpu, gate.periph, gate.timers}, 3'h1);
      chk(ram_at_risk, 1'b0);
      pulse_src(HSC_SRC_CONV_DONE);
      idle_check(20);
      pulse_src(3);
      wait_resume(n, ri);
      chk(ri, 1'b1);
   endtask
   task automatic sc_osc();
      irq_enabled_state <= 1'b0;
      halt_in(8'h88, 1'b0);
      repeat (3) begin
         @(posedge clk);
         #1 chk(clk_out, 1'b1);
      end
      chk({gate.timers, gate.osc}, 2'h1);
      pulse_src(HSC_SRC_EXT_ONE);
      idle_check(20);
      pulse_src(HSC_SRC_NMI);
      wait_resume(n, ri);
      chk(ri, 1'b1);
      chk(n <= 8, 1'b1);
   endtask
   task automatic sc_stop(input logic [7:0] mode, input int cyc, input logic hiz);
      irq_enabled_state <= 1'b1;
      halt_in(mode, 1'b0);
      chk(pin_hiz, hiz);
      chk(gate.osc, 1'b0);
      pulse_src(HSC_SRC_EXT_ZERO);
      wait_resume(n, ri);
      chk(n >= cyc && n <= cyc + 8, 1'b1);
      chk(ri, 1'b1);
   endtask
   task automatic sc_reset_in_stop();
      halt_in(8'h84, 1'b0);
      do_reset();
      @(posedge clk);
      #1 chk(halted, 1'b0);
      chk(gate.osc, 1'b1);
      rd_reg(HSC_MODE_ADDR, d);
      chk(d, HSC_MODE_RESET);
   endtask

   initial begin
      do_reset();
      sc_regs();
      wr_reg(HSC_MODE_ADDR, 8'h80);
      sc_cpu_only();
      sc_timers();
      sc_osc();
      sc_stop(8'h84, 16, 1'b1);
      sc_stop(8'h95, 64, 1'b0);
      sc_reset_in_stop();
      tally_and_finish();
   end
endmodule
